/* design/rch_receiver_cmd.sv */
// Receiver command interpreter with two timed discrete outputs
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module rch_receiver_cmd #(
  parameter int          SEC_CYCLES = rch_pkg::SEC_CYCLES,
  parameter logic [15:0] FW_VERSION = 16'h0100  // Arbitrary value
) (
  input  wire logic                clk,       // 250 MHz clock
  input  wire logic                rst_b,     // Sync reset, low
  input  wire rch_pkg::rchBusReq_t busReq,    // Register request
  output logic [31:0]              busRdata,  // Read data, next cycle
  input  wire rch_pkg::rchTagRead_t tagRead,  // Tag read report
  output logic [1:0]               outLine    // Discrete outputs
);
  localparam int PRE_W = rch_pkg::PRE_W;

  rch_pkg::rchState_t s_q;
  rch_pkg::rchState_t s_d;
  logic [7:0] ch;
  logic       isDig;
  logic       exec;
  logic [7:0] rc;
  logic       qry;
  logic [1:0] imm;
  logic [1:0] trig;
  logic [5:0] hit;
  logic       tagHit;

  function automatic logic [5:0] rch_find(
    input logic [rch_pkg::LIST_MAX-1:0][7:0] l,
    input logic [5:0]                        n,
    input logic [7:0]                        v);
    logic [5:0] r;
    r = rch_pkg::NO_HIT;
    for (int k = rch_pkg::LIST_MAX - 1; k >= 0; k--) begin
      if (6'(k) < n && l[k] == v) r = 6'(k);
    end
    return r;
  endfunction : rch_find

  // Commands accepted with no local effect (serial, baud, Wiegand framing)
  function automatic logic rch_ack_only(input logic [9:0] c);
    case (c)
      10'h00f, 10'h012, 10'h013, 10'h014, 10'h015, 10'h016, 10'h017,
      10'h018, 10'h019, 10'h01d, 10'h020, 10'h021, 10'h023, 10'h024,
      10'h027: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : rch_ack_only

  always_comb begin
    s_d    = s_q;
    ch     = busReq.wdata[7:0];
    isDig  = ch >= rch_pkg::CH_0 && ch <= rch_pkg::CH_9;
    exec   = 1'b0;
    rc     = rch_pkg::RC_OK;
    qry    = 1'b0;
    imm    = 2'b00;
    hit    = rch_find(s_q.list, s_q.count, s_q.num[7:0]);
    tagHit = rch_find(s_q.list, s_q.count, tagRead.code) != rch_pkg::NO_HIT;
    trig   = 2'b00;

    // Read data stands only in the cycle after the strobe
    s_d.rdata = '0;
    if (busReq.rd) begin
      case (busReq.addr)
        rch_pkg::A_CMD:   s_d.rdata = 32'({s_q.respQry, s_q.respRdy,
                                           s_q.respCode});
        rch_pkg::A_DEVID: s_d.rdata = 32'(s_q.devId);
        rch_pkg::A_FWVER: s_d.rdata = 32'(FW_VERSION);
        rch_pkg::A_CFG:   s_d.rdata = 32'({s_q.validEn, s_q.alarmEn,
                                           s_q.wgAlarm});
        rch_pkg::A_TIMES: s_d.rdata = 32'({s_q.wgId, s_q.spacing,
                                           s_q.dupWin});
        rch_pkg::A_DUR:   s_d.rdata = 32'({s_q.dur[1], s_q.dur[0]});
        rch_pkg::A_LCNT:  s_d.rdata = 32'(s_q.count);
        rch_pkg::A_LIDX:  s_d.rdata = (s_q.idx < s_q.count) ?
                                      32'(s_q.list[s_q.idx]) : '0;
        rch_pkg::A_STAT:  s_d.rdata = 32'(s_q.out);
        default:          s_d.rdata = '0;
      endcase
      if (busReq.addr == rch_pkg::A_CMD) s_d.respRdy = 1'b0;
    end
    if (busReq.wr && busReq.addr == rch_pkg::A_LIDX) begin
      s_d.idx = busReq.wdata[5:0];
    end

    // Character parser: digits accumulate, any other byte except a CR or LF with no digits pending ends a command
    if (busReq.wr && busReq.addr == rch_pkg::A_CMD) begin
      if (isDig) begin
        if (s_q.nDig == rch_pkg::MAX_DIG) begin
          s_d.bad = 1'b1;
        end else begin
          s_d.num  = 10'(13'(s_q.num) * 13'h00a + 13'(ch[3:0]));
          s_d.nDig = s_q.nDig + 2'h1;
        end
      end else if ((ch == rch_pkg::CH_CR || ch == rch_pkg::CH_LF) &&
                   s_q.nDig == '0 && !s_q.bad) begin
        s_d.bad = 1'b0; // Idle line ending, ignored
      end else begin
        exec = 1'b1;
      end
    end

    if (exec) begin
      s_d.num  = '0;
      s_d.nDig = '0;
      s_d.bad  = 1'b0;
      if (s_q.bad || s_q.nDig == '0) begin
        rc = rch_pkg::RC_CMD;
      end else begin
        case (ch)
          rch_pkg::CH_C: begin
            case (s_q.num)
              rch_pkg::C_OUT1:      imm[0] = 1'b1;
              rch_pkg::C_OUT2:      imm[1] = 1'b1;
              rch_pkg::C_ALM1_OFF:  s_d.alarmEn[0] = 1'b0;
              rch_pkg::C_ALM1_ON:   s_d.alarmEn[0] = 1'b1;
              rch_pkg::C_ALM2_OFF:  s_d.alarmEn[1] = 1'b0;
              rch_pkg::C_ALM2_ON:   s_d.alarmEn[1] = 1'b1;
              rch_pkg::C_VR1_OFF:   s_d.validEn[0] = 1'b0;
              rch_pkg::C_VR1_ON:    s_d.validEn[0] = 1'b1;
              rch_pkg::C_VR2_OFF:   s_d.validEn[1] = 1'b0;
              rch_pkg::C_VR2_ON:    s_d.validEn[1] = 1'b1;
              rch_pkg::C_WGALM_OFF: s_d.wgAlarm = 1'b0;
              rch_pkg::C_WGALM_ON:  s_d.wgAlarm = 1'b1;
              rch_pkg::C_LIST_DEF, rch_pkg::C_LIST_CLR: begin
                // Default list kept as the single entry; never empty
                s_d.list    = '0;
                s_d.list[0] = rch_pkg::LIST_RST;
                s_d.count   = 6'h01;
              end
              rch_pkg::C_QCFG, rch_pkg::C_QPING: qry = 1'b1;
              default: rc = rch_ack_only(s_q.num) ?
                            rch_pkg::RC_OK : rch_pkg::RC_CMD;
            endcase
          end
          rch_pkg::CH_D, rch_pkg::CH_E: begin
            if (s_q.num > rch_pkg::BYTE_MAX) begin
              rc = rch_pkg::RC_RANGE;
            end else if (ch == rch_pkg::CH_D) begin
              s_d.dur[0] = s_q.num[7:0];
            end else begin
              s_d.dur[1] = s_q.num[7:0];
            end
          end
          rch_pkg::CH_I: begin
            if (s_q.num > rch_pkg::DEVID_MAX) rc = rch_pkg::RC_RANGE;
            else s_d.devId = s_q.num;
          end
          rch_pkg::CH_L: begin
            if (s_q.num > rch_pkg::BYTE_MAX) rc = rch_pkg::RC_RANGE;
            else s_d.dupWin = s_q.num[7:0];
          end
          rch_pkg::CH_T: begin
            if (s_q.num > rch_pkg::BYTE_MAX) rc = rch_pkg::RC_RANGE;
            else s_d.spacing = s_q.num[7:0];
          end
          rch_pkg::CH_W: begin
            if (s_q.num < rch_pkg::WGID_MIN || s_q.num > rch_pkg::WGID_MAX)
              rc = rch_pkg::RC_RANGE;
            else s_d.wgId = s_q.num[7:0];
          end
          rch_pkg::CH_ADD: begin
            if (s_q.num > rch_pkg::BYTE_MAX) begin
              rc = rch_pkg::RC_RANGE;
            end else if (hit != rch_pkg::NO_HIT) begin
              rc = rch_pkg::RC_DUP;
            end else if (s_q.count == 6'(rch_pkg::LIST_MAX)) begin
              rc = rch_pkg::RC_FULL;
            end else begin
              s_d.list[s_q.count] = s_q.num[7:0];
              s_d.count = s_q.count + 6'h01;
            end
          end
          rch_pkg::CH_DEL: begin
            if (s_q.num > rch_pkg::BYTE_MAX) begin
              rc = rch_pkg::RC_RANGE;
            end else if (hit == rch_pkg::NO_HIT) begin
              rc = rch_pkg::RC_ABSENT;
            end else if (s_q.count == 6'h01) begin
              rc = rch_pkg::RC_EMPTY;
            end else begin
              // Close the gap so entries stay packed below count
              for (int k = 0; k < rch_pkg::LIST_MAX - 1; k++) begin
                if (6'(k) >= hit) s_d.list[k] = s_q.list[k+1];
              end
              s_d.list[rch_pkg::LIST_MAX-1] = '0;
              s_d.count = s_q.count - 6'h01;
            end
          end
          default: rc = rch_pkg::RC_CMD;
        endcase
      end
      // A new answer wins over a read clearing the previous one
      s_d.respRdy  = 1'b1;
      s_d.respCode = rc;
      s_d.respQry  = qry;
    end

    for (int i = 0; i < 2; i++) begin
      trig[i] = imm[i] | (tagRead.valid &
                ((s_q.alarmEn[i] & tagRead.code == rch_pkg::ALARM_CODE) |
                 (s_q.validEn[i] & tagHit)));
      if (trig[i]) begin
        s_d.remain[i] = s_q.dur[i];
        s_d.pre[i]    = '0;
      end else if (s_q.remain[i] != '0) begin
        if (s_q.pre[i] == PRE_W'(SEC_CYCLES - 1)) begin
          s_d.pre[i]    = '0;
          s_d.remain[i] = s_q.remain[i] - 8'h01;
        end else begin
          s_d.pre[i] = s_q.pre[i] + PRE_W'(1);
        end
      end
      s_d.out[i] = s_d.remain[i] != '0;
    end

    if (!rst_b) begin
      s_d         = '0;
      s_d.devId   = rch_pkg::DEVID_RST;
      s_d.dur[0]  = rch_pkg::DUR_RST;
      s_d.dur[1]  = rch_pkg::DUR_RST;
      s_d.dupWin  = rch_pkg::DUPWIN_RST;
      s_d.spacing = rch_pkg::SPACING_RST;
      s_d.wgId    = rch_pkg::WGID_RST;
      s_d.list[0] = rch_pkg::LIST_RST;
      s_d.count   = 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign busRdata = s_q.rdata;
  assign outLine  = s_q.out;

  // Well-formed command executing this cycle, and its c-code form
  logic numCmd;
  logic cmdC;
  assign numCmd = exec && !s_q.bad && s_q.nDig != '0;
  assign cmdC   = numCmd && ch == rch_pkg::CH_C;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  alarm_out1_a: assert property (tagRead.valid && s_q.alarmEn[0] &&
      tagRead.code == rch_pkg::ALARM_CODE && s_q.dur[0] != '0 |=> outLine[0])
    else $error("output 1 missed alarm trigger");
  alarm_out2_a: assert property (tagRead.valid && s_q.alarmEn[1] &&
      tagRead.code == rch_pkg::ALARM_CODE && s_q.dur[1] != '0 |=> outLine[1])
    else $error("output 2 missed alarm trigger");
  quiet_out_a: assert property (!trig[0] && s_q.remain[0] == '0
      |=> !outLine[0])
    else $error("output 1 asserted without trigger");
  imm_load_a: assert property (exec && ch == rch_pkg::CH_C &&
      s_q.num == rch_pkg::C_OUT2 && !s_q.bad && s_q.nDig != '0
      |=> s_q.remain[1] == $past(s_q.dur[1]))
    else $error("immediate command did not load output 2");
  hold_end_a: assert property ($fell(outLine[0]) |->
      $past(s_q.remain[0]) == 8'h01 && $past(s_q.pre[0]) ==
      PRE_W'(SEC_CYCLES - 1))
    else $error("output 1 dropped early");
  range_keep_a: assert property (exec && ch == rch_pkg::CH_D &&
      !s_q.bad && s_q.nDig != '0 && s_q.num > rch_pkg::BYTE_MAX
      |=> s_q.respCode == rch_pkg::RC_RANGE && $stable(s_q.dur[0]))
    else $error("out of range value not refused");
  list_full_a: assert property (exec && ch == rch_pkg::CH_ADD &&
      !s_q.bad && s_q.nDig != '0 && s_q.num <= rch_pkg::BYTE_MAX &&
      hit == rch_pkg::NO_HIT && s_q.count == 6'(rch_pkg::LIST_MAX)
      |=> s_q.respCode == rch_pkg::RC_FULL && $stable(s_q.count))
    else $error("full list not refused");
  list_bound_a: assert property (s_q.count >= 6'h01 &&
      s_q.count <= 6'(rch_pkg::LIST_MAX))
    else $error("list size out of bounds");
  resp_set_a: assert property (exec |=> s_q.respRdy ##1
      (s_q.respRdy || $past(busReq.rd && busReq.addr == rch_pkg::A_CMD)))
    else $error("answer not posted");
  bad_cmd_a: assert property (exec && s_q.bad
      |=> s_q.respCode == rch_pkg::RC_CMD)
    else $error("malformed command not answered 06");

  alm1_on_a: assert property (cmdC &&
      s_q.num == rch_pkg::C_ALM1_ON |=> s_q.alarmEn[0])
    else $error("alarm enable 1 not set");

  alm1_off_a: assert property (cmdC &&
      s_q.num == rch_pkg::C_ALM1_OFF |=> !s_q.alarmEn[0])
    else $error("alarm enable 1 not cleared");

  alm2_on_a: assert property (cmdC &&
      s_q.num == rch_pkg::C_ALM2_ON |=> s_q.alarmEn[1])
    else $error("alarm enable 2 not set");

  alm2_off_a: assert property (cmdC &&
      s_q.num == rch_pkg::C_ALM2_OFF |=> !s_q.alarmEn[1])
    else $error("alarm enable 2 not cleared");

  vr1_on_a: assert property (cmdC &&
      s_q.num == rch_pkg::C_VR1_ON |=> s_q.validEn[0])
    else $error("valid-read enable 1 not set");

  vr1_off_a: assert property (cmdC &&
      s_q.num == rch_pkg::C_VR1_OFF |=> !s_q.validEn[0])
    else $error("valid-read enable 1 not cleared");

  vr2_on_a: assert property (cmdC &&
      s_q.num == rch_pkg::C_VR2_ON |=> s_q.validEn[1])
    else $error("valid-read enable 2 not set");

  vr2_off_a: assert property (cmdC &&
      s_q.num == rch_pkg::C_VR2_OFF |=> !s_q.validEn[1])
    else $error("valid-read enable 2 not cleared");

  valid_out2_a: assert property (tagRead.valid && s_q.validEn[1] &&
      tagHit && s_q.dur[1] != '0 |=> outLine[1])
    else $error("output 2 missed valid read");

  wg_on_a: assert property (cmdC &&
      s_q.num == rch_pkg::C_WGALM_ON |=> s_q.wgAlarm)
    else $error("status reporting not enabled");

  wg_off_a: assert property (cmdC &&
      s_q.num == rch_pkg::C_WGALM_OFF |=> !s_q.wgAlarm)
    else $error("status reporting not disabled");

  imm_out1_a: assert property (cmdC && s_q.num == rch_pkg::C_OUT1 &&
      s_q.dur[0] != '0 |=> outLine[0])
    else $error("immediate command did not raise output 1");

  query_flag_a: assert property (cmdC &&
      (s_q.num == rch_pkg::C_QCFG || s_q.num == rch_pkg::C_QPING)
      |=> s_q.respQry && s_q.respCode == rch_pkg::RC_OK)
    else $error("query answer not flagged");

  dur_set_a: assert property (numCmd && ch == rch_pkg::CH_D &&
      s_q.num <= rch_pkg::BYTE_MAX
      |=> s_q.dur[0] == $past(s_q.num[7:0]))
    else $error("output 1 duration not stored");

  spacing_ok_a: assert property (numCmd && ch == rch_pkg::CH_T &&
      s_q.num <= rch_pkg::BYTE_MAX |=> s_q.respCode == rch_pkg::RC_OK &&
      s_q.spacing == $past(s_q.num[7:0]))
    else $error("accepted value not acknowledged");

  dev_range_a: assert property (numCmd && ch == rch_pkg::CH_I &&
      s_q.num > rch_pkg::DEVID_MAX
      |=> s_q.respCode == rch_pkg::RC_RANGE && $stable(s_q.devId))
    else $error("device identifier range not refused");

  list_dup_a: assert property (numCmd && ch == rch_pkg::CH_ADD &&
      s_q.num <= rch_pkg::BYTE_MAX && hit != rch_pkg::NO_HIT
      |=> s_q.respCode == rch_pkg::RC_DUP && $stable(s_q.count))
    else $error("duplicate entry not refused");

  list_absent_a: assert property (numCmd && ch == rch_pkg::CH_DEL &&
      s_q.num <= rch_pkg::BYTE_MAX && hit == rch_pkg::NO_HIT
      |=> s_q.respCode == rch_pkg::RC_ABSENT && $stable(s_q.count))
    else $error("absent entry not refused");

  list_last_a: assert property (numCmd && ch == rch_pkg::CH_DEL &&
      s_q.num <= rch_pkg::BYTE_MAX && hit != rch_pkg::NO_HIT &&
      s_q.count == 6'h01
      |=> s_q.respCode == rch_pkg::RC_EMPTY && $stable(s_q.count))
    else $error("last entry removed");

  rdata_idle_a: assert property (!busReq.rd |=> busRdata == '0)
    else $error("read data outside its cycle");
endmodule : rch_receiver_cmd

/* pkg/rch_pkg.sv */
// Constants, carrier structs and state type of the receiver command handler
package rch_pkg;
  localparam int LIST_MAX    = 34;
  localparam int PRE_W       = 28;
  localparam int CLK_HZ      = 250_000_000;
  localparam int HOLD_UNIT_S = 1;
  localparam int SEC_CYCLES  = HOLD_UNIT_S * CLK_HZ;

  localparam logic [3:0] A_CMD   = 4'h0;
  localparam logic [3:0] A_DEVID = 4'h1;
  localparam logic [3:0] A_FWVER = 4'h2;
  localparam logic [3:0] A_CFG   = 4'h3;
  localparam logic [3:0] A_TIMES = 4'h4;
  localparam logic [3:0] A_DUR   = 4'h5;
  localparam logic [3:0] A_LCNT  = 4'h6;
  localparam logic [3:0] A_LIDX  = 4'h7;
  localparam logic [3:0] A_STAT  = 4'h8;

  localparam logic [7:0] DUR_RST     = 8'h05;
  localparam logic [7:0] DUPWIN_RST  = 8'h7d;
  localparam logic [7:0] SPACING_RST = 8'h0d;
  localparam logic [7:0] WGID_RST    = 8'h7f;
  localparam logic [9:0] DEVID_RST   = 10'h001;
  localparam logic [7:0] LIST_RST    = 8'h7f;
  localparam logic [9:0] BYTE_MAX    = 10'h0ff;
  localparam logic [9:0] DEVID_MAX   = 10'h3e7;
  localparam logic [9:0] WGID_MIN    = 10'h001;
  localparam logic [9:0] WGID_MAX    = 10'h0fa;
  localparam logic [7:0] ALARM_CODE  = 8'h00;
  localparam logic [5:0] NO_HIT      = 6'h3f;
  localparam logic [1:0] MAX_DIG     = 2'h3;

  localparam logic [7:0] RC_OK    = 8'h00;
  localparam logic [7:0] RC_DUP   = 8'h01;
  localparam logic [7:0] RC_FULL  = 8'h02;
  localparam logic [7:0] RC_EMPTY = 8'h03;
  localparam logic [7:0] RC_ABSENT = 8'h04;
  localparam logic [7:0] RC_RANGE = 8'h05;
  localparam logic [7:0] RC_CMD   = 8'h06;

  localparam logic [9:0] C_OUT1      = 10'h00a;
  localparam logic [9:0] C_OUT2      = 10'h00b;
  localparam logic [9:0] C_WGALM_OFF = 10'h00c;
  localparam logic [9:0] C_ALM1_OFF  = 10'h00d;
  localparam logic [9:0] C_ALM2_OFF  = 10'h00e;
  localparam logic [9:0] C_VR1_OFF   = 10'h010;
  localparam logic [9:0] C_VR2_OFF   = 10'h011;
  localparam logic [9:0] C_WGALM_ON  = 10'h01a;
  localparam logic [9:0] C_ALM1_ON   = 10'h01b;
  localparam logic [9:0] C_ALM2_ON   = 10'h01c;
  localparam logic [9:0] C_VR1_ON    = 10'h01e;
  localparam logic [9:0] C_VR2_ON    = 10'h01f;
  localparam logic [9:0] C_LIST_DEF  = 10'h022;
  localparam logic [9:0] C_LIST_CLR  = 10'h025;
  localparam logic [9:0] C_QCFG      = 10'h026;
  localparam logic [9:0] C_QPING     = 10'h028;

  localparam logic [7:0] CH_0   = 8'h30;
  localparam logic [7:0] CH_9   = 8'h39;
  localparam logic [7:0] CH_C   = 8'h63;
  localparam logic [7:0] CH_D   = 8'h44;
  localparam logic [7:0] CH_E   = 8'h45;
  localparam logic [7:0] CH_I   = 8'h49;
  localparam logic [7:0] CH_L   = 8'h4c;
  localparam logic [7:0] CH_T   = 8'h54;
  localparam logic [7:0] CH_W   = 8'h57;
  localparam logic [7:0] CH_ADD = 8'h2b;
  localparam logic [7:0] CH_DEL = 8'h2d;
  localparam logic [7:0] CH_CR  = 8'h0d;
  localparam logic [7:0] CH_LF  = 8'h0a;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rchBusReq_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } rchTagRead_t;

  typedef struct packed {
    logic [9:0]                    num;
    logic [1:0]                    nDig;
    logic                          bad;
    logic [9:0]                    devId;
    logic [1:0][7:0]               dur;
    logic [7:0]                    dupWin;
    logic [7:0]                    spacing;
    logic [7:0]                    wgId;
    logic [1:0]                    alarmEn;
    logic [1:0]                    validEn;
    logic                          wgAlarm;
    logic [5:0]                    count;
    logic [LIST_MAX-1:0][7:0]      list;
    logic [5:0]                    idx;
    logic [1:0][7:0]               remain;
    logic [1:0][PRE_W-1:0]         pre;
    logic                          respRdy;
    logic                          respQry;
    logic [7:0]                    respCode;
    logic [31:0]                   rdata;
    logic [1:0]                    out;
  } rchState_t;
endpackage : rch_pkg

/* verification/rch_host_model.sv */
// Host-side model: bus master that sends ASCII commands and collects replies
`timescale 1ns/1ns
module rch_host_model #(
  parameter int GAP   = 8,  // Shortened command spacing for simulation
  parameter int POLLS = 4   // Reply polls before a resend
) (
  input  wire logic        clk,    // Bus clock
  output rch_pkg::rchBusReq_t req, // Register request
  input  wire logic [31:0] rdata   // Read data, one cycle after rd
);
  initial req = '0;

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  // Write data is inverted on reads so a stale value never looks valid
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: ~req.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd

  // One command at a time; resend only when no reply shows up
  task automatic send(input string s, output logic [31:0] resp);
    resp = '0;
    for (int t = 0; t < 2 && resp[8] !== 1'b1; t++) begin
      for (int i = 0; i < s.len(); i++) begin
        wr(rch_pkg::A_CMD, {24'h0, s[i]});
      end
      for (int p = 0; p < POLLS && resp[8] !== 1'b1; p++) begin
        rd(rch_pkg::A_CMD, resp);
      end
    end
    repeat (GAP) @(posedge clk);
  endtask : send
endmodule : rch_host_model

/* verification/tb.sv */
// Self-checking bench for the receiver command handler
`timescale 1ns/1ns
module tb;
  localparam int          SEC   = 10;
  localparam logic [15:0] FWV   = 16'h5a3c;  // Arbitrary value
  localparam int          LIMIT = 40000;

  logic                 clk     = 1'b0;
  logic                 rst_b   = 1'b0;
  rch_pkg::rchBusReq_t  busReq;
  rch_pkg::rchTagRead_t tagRead = '0;
  logic [31:0]          busRdata;
  logic [1:0]           outLine;
  int                   num_errors = 0;
  int                   checked    = 0;
  int                   cyc        = 0;
  int                   hiCnt [2]  = '{0, 0};
  int                   exp0       = 0;
  int                   exp1       = 0;
  logic [31:0]          r;
  string cfgCmd [10] = '{"27c", "28c", "30c", "31c", "26c",
                         "13c", "14c", "16c", "17c", "12c"};
  logic [31:0] cfgExp [10] = '{32'h02, 32'h06, 32'h0e, 32'h1e, 32'h1f,
                               32'h1d, 32'h19, 32'h11, 32'h01, 32'h00};
  string bad [5] = '{"c", "41c", "12X", "7\r", "1000I"};

  always #2 clk = ~clk;

  rch_receiver_cmd #(.SEC_CYCLES(SEC), .FW_VERSION(FWV)) DUT (
    .clk      (clk),
    .rst_b    (rst_b),
    .busReq   (busReq),
    .busRdata (busRdata),
    .tagRead  (tagRead),
    .outLine  (outLine)
  );

  rch_host_model host (.clk(clk), .req(busReq), .rdata(busRdata));

  // High time is summed per output so each pulse length shows as a delta
  always @(posedge clk) begin
    cyc++;
    if (outLine[0] === 1'b1) hiCnt[0]++;
    if (outLine[1] === 1'b1) hiCnt[1]++;
    if (cyc == LIMIT) begin
      num_errors++;
      $display("Error at %0t: run did not finish", $time);
      conclude();
    end
  end

  task automatic conclude();
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input string s, input logic [7:0] code);
    host.send(s, r);
    chk(r, {24'h1, code});
  endtask : cmd

  task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
    host.rd(a, r);
    chk(r, e);
  endtask : rdChk

  task automatic tag(input logic [7:0] c);
    @(posedge clk);
    tagRead <= '{valid: 1'b1, code: c};
    @(posedge clk);
    tagRead.valid <= 1'b0;
  endtask : tag

  // Long enough for the longest pulse plus a retrigger to finish
  task automatic hold(input int e0, input int e1);
    repeat (100) @(posedge clk);
    exp0 += e0;
    exp1 += e1;
    chk(hiCnt[0], exp0);
    chk(hiCnt[1], exp1);
  endtask : hold

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rdChk(rch_pkg::A_CMD, 32'h0);
    rdChk(rch_pkg::A_DEVID, 32'h1);
    rdChk(rch_pkg::A_DUR, 32'h0505);
    rdChk(rch_pkg::A_TIMES, 32'h7f0d7d);
    rdChk(rch_pkg::A_CFG, 32'h0);
    rdChk(rch_pkg::A_LCNT, 32'h1);
    host.wr(rch_pkg::A_LIDX, 32'h0);
    rdChk(rch_pkg::A_LIDX, 32'h7f);
    rdChk(4'h9, 32'h0);
    for (int i = 0; i < 10; i++) begin
      cmd(cfgCmd[i], rch_pkg::RC_OK);
      rdChk(rch_pkg::A_CFG, cfgExp[i]);
    end
    for (int i = 0; i < 5; i++) cmd(bad[i], rch_pkg::RC_CMD);
    cmd("999I", rch_pkg::RC_OK);
    rdChk(rch_pkg::A_DEVID, 32'h3e7);
    cmd("0W", rch_pkg::RC_RANGE);
    cmd("251W", rch_pkg::RC_RANGE);
    cmd("250W", rch_pkg::RC_OK);
    cmd("256L", rch_pkg::RC_RANGE);
    cmd("255L", rch_pkg::RC_OK);
    cmd("0T", rch_pkg::RC_OK);
    rdChk(rch_pkg::A_TIMES, 32'hfa00ff);
    cmd("256D", rch_pkg::RC_RANGE);
    cmd("256E", rch_pkg::RC_RANGE);
    cmd("\n3D", rch_pkg::RC_OK);
    cmd("2E", rch_pkg::RC_OK);
    rdChk(rch_pkg::A_DUR, 32'h0203);
    cmd("15c", rch_pkg::RC_OK);
    host.send("38c", r);
    chk(r, 32'h300);
    host.send("40c", r);
    chk(r, 32'h300);
    rdChk(rch_pkg::A_FWVER, {16'h0, FWV});
    cmd("127+", rch_pkg::RC_DUP);
    cmd("256+", rch_pkg::RC_RANGE);
    cmd("127-", rch_pkg::RC_EMPTY);
    cmd("9-", rch_pkg::RC_ABSENT);
    cmd("5+", rch_pkg::RC_OK);
    host.wr(rch_pkg::A_LIDX, 32'h1);
    rdChk(rch_pkg::A_LIDX, 32'h5);
    for (int k = 10; k < 42; k++) cmd($sformatf("%0d+", k), 8'h00);
    cmd("50+", rch_pkg::RC_FULL);
    rdChk(rch_pkg::A_LCNT, 32'd34);
    cmd("5-", rch_pkg::RC_OK);
    rdChk(rch_pkg::A_LCNT, 32'd33);
    cmd("37c", rch_pkg::RC_OK);
    rdChk(rch_pkg::A_LCNT, 32'd1);
    cmd("10c", rch_pkg::RC_OK);
    rdChk(rch_pkg::A_STAT, 32'h1);
    hold(3 * SEC, 0);
    cmd("11c", rch_pkg::RC_OK);
    hold(0, 2 * SEC);
    tag(8'h00);
    hold(0, 0);
    cmd("27c", rch_pkg::RC_OK);
    tag(8'h00);
    hold(3 * SEC, 0);
    cmd("28c", rch_pkg::RC_OK);
    tag(8'h00);
    hold(3 * SEC, 2 * SEC);
    cmd("13c", rch_pkg::RC_OK);
    cmd("14c", rch_pkg::RC_OK);
    cmd("30c", rch_pkg::RC_OK);
    tag(8'h7f);
    hold(3 * SEC, 0);
    tag(8'h05);
    hold(0, 0);
    cmd("31c", rch_pkg::RC_OK);
    tag(8'h7f);
    hold(3 * SEC, 2 * SEC);
    cmd("16c", rch_pkg::RC_OK);
    cmd("17c", rch_pkg::RC_OK);
    cmd("27c", rch_pkg::RC_OK);
    tag(8'h00);
    repeat (13) @(posedge clk);
    tag(8'h00);
    hold(15 + 3 * SEC, 0);
    cmd("0D", rch_pkg::RC_OK);
    cmd("10c", rch_pkg::RC_OK);
    rdChk(rch_pkg::A_STAT, 32'h0);
    hold(0, 0);
    conclude();
  end
endmodule : tb
